// *** lpwt_top.sv ***
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Function
// - timeout completion wakes system from idle or power down, raises irq
// - counter runs from low-power rc clock through selected prescaler
// - counting continues during idle and power down
// - control bit 7 enables the timer when set
// - writing one to bit 6 zeroes the count and prescaler
// - clear bit self-clears in hardware, reads back zero
// - bits 2:0 choose divide by 1,4,8,32,64,256,512,1024
// - timeout after 64 prescaled clock periods
// - bit 5 flag set on overflow, held until software writes zero
// - timer irq only when wake irq enable and global enable both set, irq only when status and mask both set
// - timeout flag is readable for polling
// - free running, repeated timeout every interval
// - bits 4:3 reserved read zero, control resets to zero
module lpwt_top (
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        rc_clk_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             wake_o,
   output logic             timer_irq_o,
   output logic             irq_o
);
   logic       rc_sync;
   logic       rc_prev_reg;
   logic       en_reg;
   logic       clr_reg;
   logic       flag_reg;
   logic [2:0] ps_reg;
   logic [7:0] irqen_reg;
   logic       status_reg;
   logic       mask_reg;
   logic       timeout;
   logic [5:0] count;

   lpwt_sync u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (rc_clk_i),
      .q_o     (rc_sync)
   );

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rc_prev_reg <= 1'b0;
      end else begin
         rc_prev_reg <= rc_sync;
      end
   end

   wire rc_tick = rc_sync && !rc_prev_reg;

   // apb decode
   wire acc      = psel_i && penable_i;
   wire wr       = acc && pwrite_i && pstrb_i[0];
   wire hit_ctrl = (paddr_i == lpwt_pkg::CTRL_OFFSET);
   wire hit_ien  = (paddr_i == lpwt_pkg::IRQ_EN_OFFSET);
   wire hit_st   = (paddr_i == lpwt_pkg::STATUS_OFFSET);
   wire hit_mask = (paddr_i == lpwt_pkg::MASK_OFFSET);
   wire hit_any  = hit_ctrl || hit_ien || hit_st || hit_mask;
   wire wr_ctrl  = wr && hit_ctrl;
   wire wr_ien   = wr && hit_ien;
   wire wr_st    = wr && hit_st;
   wire wr_mask  = wr && hit_mask;

   wire [7:0] ctrl_val = {en_reg, 1'b0, flag_reg, 2'b00, ps_reg};
   wire [31:0] rd_val = hit_ctrl ? {24'h000000, ctrl_val} :
                        hit_ien  ? {24'h000000, irqen_reg} :
                        hit_st   ? {31'h00000000, status_reg} :
                        hit_mask ? {31'h00000000, mask_reg} :
                        32'h00000000;

   wire lpwt_pkg::lpwt_cfg_s cfg = '{enable: en_reg, clear: clr_reg,
                                     prescale: ps_reg};

   lpwt_counter u_counter (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .rc_tick_i (rc_tick),
      .cfg_i     (cfg),
      .timeout_o (timeout),
      .count_o   (count)
   );

   wire flag_clr   = wr_ctrl && !pwdata_i[lpwt_pkg::CTRL_FLAG_BIT];
   wire flag_next  = timeout || (flag_reg && !flag_clr);
   wire st_clr     = wr_st && pwdata_i[lpwt_pkg::EVT_TIMEOUT_BIT];
   wire st_next    = timeout || (status_reg && !st_clr);
   wire irq_gate   = irqen_reg[lpwt_pkg::IRQEN_WAKE_BIT] &&
                     irqen_reg[lpwt_pkg::IRQEN_GLOBAL_BIT];

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_reg    <= 1'b0;
         clr_reg   <= 1'b0;
         ps_reg    <= 3'h0;
         flag_reg  <= 1'b0;
         irqen_reg <= lpwt_pkg::IRQEN_RESET;
         status_reg <= 1'b0;
         mask_reg  <= 1'b0;
      end else begin
         flag_reg   <= flag_next;
         status_reg <= st_next;
         clr_reg    <= wr_ctrl && pwdata_i[lpwt_pkg::CTRL_CLR_BIT];
         if (wr_ctrl) begin
            en_reg <= pwdata_i[lpwt_pkg::CTRL_EN_BIT];
            ps_reg <= pwdata_i[lpwt_pkg::CTRL_PS_HI:0];
         end
         if (wr_ien) begin
            irqen_reg <= pwdata_i[7:0];
         end
         if (wr_mask) begin
            mask_reg <= pwdata_i[lpwt_pkg::EVT_TIMEOUT_BIT];
         end
      end
   end

   // outputs registered
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o    <= 32'h00000000;
         pready_o    <= 1'b0;
         pslverr_o   <= 1'b0;
         wake_o      <= 1'b0;
         timer_irq_o <= 1'b0;
         irq_o       <= 1'b0;
      end else begin
         pready_o    <= psel_i && !penable_i;
         pslverr_o   <= psel_i && !penable_i && !hit_any;
         prdata_o    <= (psel_i && !penable_i) ? rd_val : 32'h00000000;
         wake_o      <= flag_next;
         timer_irq_o <= flag_next && irq_gate;
         irq_o       <= st_next && mask_reg;
      end
   end
endmodule : lpwt_top

// *** lpwt_pkg.sv ***
package lpwt_pkg;

   // register byte offsets (one aligned word each)
   // control is word index 0xab, byte address four times that
   localparam logic [11:0] CTRL_INDEX    = 12'h0ab;
   localparam logic [11:0] CTRL_OFFSET   = CTRL_INDEX << 2;
   localparam logic [11:0] IRQ_EN_OFFSET = 12'h100;
   localparam logic [11:0] STATUS_OFFSET = 12'h104;
   localparam logic [11:0] MASK_OFFSET   = 12'h108;

   // control register fields
   localparam int CTRL_EN_BIT    = 7;
   localparam int CTRL_CLR_BIT   = 6;
   localparam int CTRL_FLAG_BIT  = 5;
   localparam int CTRL_PS_HI     = 2;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CTRL_WR_MASK = 8'hc7;

   // extended irq enable register fields
   localparam int IRQEN_WAKE_BIT = 1;
   localparam int IRQEN_GLOBAL_BIT = 7;
   localparam logic [7:0] IRQEN_RESET = 8'h00;

   // status/mask: bit 0 timeout event
   localparam int EVT_TIMEOUT_BIT = 0;

   // timing
   localparam int  RC_FREQ_HZ     = 10000;
   localparam int  TIMEOUT_TICKS  = 64;
   localparam logic [5:0] TICK_LAST = 6'h3f;
   localparam logic [10:0] DIV_LAST_1    = 11'h000;
   localparam logic [10:0] DIV_LAST_4    = 11'h003;
   localparam logic [10:0] DIV_LAST_8    = 11'h007;
   localparam logic [10:0] DIV_LAST_32   = 11'h01f;
   localparam logic [10:0] DIV_LAST_64   = 11'h03f;
   localparam logic [10:0] DIV_LAST_256  = 11'h0ff;
   localparam logic [10:0] DIV_LAST_512  = 11'h1ff;
   localparam logic [10:0] DIV_LAST_1024 = 11'h3ff;

   typedef struct packed {
      logic       enable;
      logic       clear;
      logic [2:0] prescale;
   } lpwt_cfg_s;

   function automatic logic [10:0] div_last(input logic [2:0] sel);
      case (sel)
         3'h0: div_last = DIV_LAST_1;
         3'h1: div_last = DIV_LAST_4;
         3'h2: div_last = DIV_LAST_8;
         3'h3: div_last = DIV_LAST_32;
         3'h4: div_last = DIV_LAST_64;
         3'h5: div_last = DIV_LAST_256;
         3'h6: div_last = DIV_LAST_512;
         default: div_last = DIV_LAST_1024;
      endcase
   endfunction : div_last

endpackage : lpwt_pkg

// *** lpwt_sync.sv ***
`timescale 1ns/1ps
// two-flop level synchroniser
module lpwt_sync (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         q_o      <= 1'b0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule : lpwt_sync

// *** lpwt_counter.sv ***
`timescale 1ns/1ps
// prescaler and 64-tick counter, advanced by rc edge pulses
module lpwt_counter (
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic              rc_tick_i,
   input  wire lpwt_pkg::lpwt_cfg_s cfg_i,
   output logic                   timeout_o,
   output logic [5:0]             count_o
);
   logic [10:0] div_reg;
   wire  [10:0] div_end  = lpwt_pkg::div_last(cfg_i.prescale);
   wire         div_wrap = rc_tick_i && (div_reg >= div_end);
   wire         cnt_wrap = div_wrap && (count_o == lpwt_pkg::TICK_LAST);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_reg   <= 11'h000;
         count_o   <= 6'h00;
         timeout_o <= 1'b0;
      end else if (cfg_i.clear) begin
         div_reg   <= 11'h000;
         count_o   <= 6'h00;
         timeout_o <= 1'b0;
      end else if (cfg_i.enable) begin
         timeout_o <= cnt_wrap;
         if (rc_tick_i) begin
            div_reg <= div_wrap ? 11'h000 : div_reg + 11'h001;
         end
         if (div_wrap) begin
            count_o <= count_o + 6'h01;
         end
      end else begin
         timeout_o <= 1'b0;
      end
   end
endmodule : lpwt_counter

// *** lpwt_rc_model.sv ***
`timescale 1ns/1ps
// rc oscillator stand-in, period of 16 system clocks, still while stopped
module lpwt_rc_model (
   input  wire logic clock_i,
   input  wire logic run_i,
   output logic      rc_clk_o
);
   logic [3:0] cnt_reg;
   always_ff @(posedge clock_i) begin
      cnt_reg <= run_i ? cnt_reg + 4'h1 : 4'h0;
   end
   assign rc_clk_o = run_i & cnt_reg[3];
endmodule : lpwt_rc_model

// *** lpwt_checker.sv ***
`timescale 1ns/1ps
module lpwt_checker (
   input wire logic        clock_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        wake_o,
   input wire logic        timer_irq_o,
   input wire logic        irq_o
);
   wire wr_any = psel_i & penable_i & pwrite_i;
   wire mapped = paddr_i inside {lpwt_pkg::CTRL_OFFSET,
      lpwt_pkg::IRQ_EN_OFFSET, lpwt_pkg::STATUS_OFFSET,
      lpwt_pkg::MASK_OFFSET};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_ctrl_read;
      pready_o && !pwrite_i && paddr_i == lpwt_pkg::CTRL_OFFSET;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
      else $error("error response wrong");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_ctrl_reserved_zero: assert property (s_ctrl_read |->
      {prdata_o[6], prdata_o[4:3]} == 3'h0)
      else $error("reserved bits not zero");
   a_irq_needs_flag: assert property (timer_irq_o |-> wake_o)
      else $error("timer irq without flag");
   a_wake_sticky: assert property ($fell(wake_o) |->
      $past(wr_any) || $past(wr_any, 2)) else $error("flag lost");
   a_irq_sticky: assert property ($fell(irq_o) |->
      $past(wr_any) || $past(wr_any, 2)) else $error("irq lost");
endmodule : lpwt_checker
bind lpwt_top lpwt_checker chk_u (.*);

// *** low_power_wakeup_timer_bench.sv ***
`timescale 1ns/1ps
module low_power_wakeup_timer_bench;
   localparam logic [11:0] C = lpwt_pkg::CTRL_OFFSET;
   localparam logic [11:0] E = lpwt_pkg::IRQ_EN_OFFSET;
   localparam logic [11:0] M = lpwt_pkg::MASK_OFFSET;
   typedef struct {logic [11:0] a; logic [31:0] w, r; logic e;} lpwt_row_s;
   logic        clock_i, rst_n_i, psel_i, penable_i, pwrite_i, run, er;
   logic        rc_clk_i, pready_o, pslverr_o, wake_o, timer_irq_o, irq_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0]  pstrb_i;
   int          errors, n_checks, i;
   lpwt_row_s rows[4] = '{'{C, 32'hff, 32'h87, 1'b0},
      '{E, 32'h82, 32'h82, 1'b0}, '{M, 32'h01, 32'h01, 1'b0},
      '{12'h200, 32'h5a, 32'h00, 1'b1}};
   lpwt_top dut_u (.*);
   lpwt_rc_model rc_u (.clock_i(clock_i), .run_i(run), .rc_clk_o(rc_clk_i));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic chk(input logic [31:0] s, x);
      n_checks++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, s, x);
      end
   endtask : chk
   task close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      psel_i   <= 1'b1;
      pwrite_i <= w;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      rd = prdata_o;
      er = pslverr_o;
      if (pready_o !== 1'b1) begin
         errors++;
         close_out;
      end
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb
   task automatic waitw(input int lim);
      for (i = 0; i < lim && wake_o !== 1'b1; i++) @(posedge clock_i);
      chk(wake_o, 1'b1);
   endtask : waitw
   task automatic tmo(input int n, input logic [7:0] ps);
      run <= 1'b0;
      apb(1'b1, C, 8'h40 | ps);
      apb(1'b1, C, 8'h80 | ps);
      run <= 1'b1;
      repeat (16 * n - 12) @(posedge clock_i);
      chk(wake_o, 1'b0);
      waitw(20);
      $display("timeout test done, %0d edges", n);
   endtask : tmo
   initial begin
      {psel_i, penable_i, pwrite_i, run, rst_n_i} = '0;
      paddr_i = '0; pwdata_i = '0; pstrb_i = 4'hf;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      apb(1'b0, C, 0);
      chk(rd, 0);
      foreach (rows[j]) begin
         apb(1'b1, rows[j].a, rows[j].w);
         apb(1'b0, rows[j].a, 0);
         chk(rd, rows[j].r);
         chk(er, rows[j].e);
      end
      for (int p = 0; p < 8; p++) begin
         apb(1'b1, C, p);
         apb(1'b0, C, 0);
         chk(rd, p);
      end
      $display("register test done");
      tmo(64, 8'h00);
      repeat (2) @(posedge clock_i);
      chk(timer_irq_o, 1'b1);
      chk(irq_o, 1'b1);
      apb(1'b0, C, 0);
      chk(rd, 32'ha0);
      apb(1'b1, C, 8'ha0);
      chk(wake_o, 1'b1);
      apb(1'b1, C, 8'h80);
      chk(wake_o, 1'b0);
      repeat (640) @(posedge clock_i);
      chk(wake_o, 1'b0);
      waitw(480);
      run <= 1'b0;
      apb(1'b1, M, 0);
      // irq outputs follow mask and enable writes one cycle later
      @(posedge clock_i);
      chk(irq_o, 1'b0);
      apb(1'b1, E, 8'h02);
      @(posedge clock_i);
      chk(timer_irq_o, 1'b0);
      apb(1'b1, M, 1);
      @(posedge clock_i);
      chk(irq_o, 1'b1);
      apb(1'b1, lpwt_pkg::STATUS_OFFSET, 1);
      chk(irq_o, 1'b0);
      $display("interrupt test done");
      tmo(256, 8'h01);
      pstrb_i <= 4'h0;
      apb(1'b1, C, 8'h07);
      pstrb_i <= 4'hf;
      apb(1'b0, C, 0);
      chk(rd, 32'ha1);
      run     <= 1'b0;
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk({wake_o, timer_irq_o, irq_o, pready_o, pslverr_o}, 0);
      rst_n_i <= 1'b1;
      apb(1'b0, C, 0);
      chk(rd, 0);
      $display("strobe and reset test done");
      close_out;
   end
endmodule : low_power_wakeup_timer_bench
